// *** hw/chirq_bank.sv ***
// channel interrupt summary, identity and per-channel register bank
// assumes a host register port on ref_clk with one-cycle strobes
// and line condition pins that are asynchronous to ref_clk
//
// What this block does
// (R1) high summary register shows channels 11 to 6
// (R2) low summary register shows channels 0 to 5
// (R3) summary bit one while channel interrupt pending
// (R4) summary bit holds until source status read
// (R5) host reads source status after summary
// (R6) part number register fixed, writes ignored
// (R7) revision register: upper nibble zero, lower revision
// (R8) twelve registers per channel, twelve channels; protection switch and error counter registers read zero here
// (R9) channels at nibbles 0-5 and 8-D
// (R10) summary bits 7 and 6 read zero
// (R11) enabled condition change raises channel interrupt
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module chirq_bank import chirq_pkg::*; #(
    parameter logic [7:0] PART_ID = 8'hA5, // value is arbitrary
    parameter logic [3:0] REV_ID = 4'h3 // value is arbitrary
) (
    input wire logic ref_clk, // system clock, 200 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wrData, // write data
    input wire logic wrStrobe, // one-cycle write strobe
    input wire logic rdStrobe, // one-cycle read strobe
    output logic [7:0] rdData, // read data, cycle after rdStrobe
    input wire logic [`CHIRQ_NUM_CH-1:0] bufLimitAlarm, // buffer_limit_alarm pins
    input wire logic [`CHIRQ_NUM_CH-1:0] receiveLockLost, // receive_lock_lost pins
    input wire logic [`CHIRQ_NUM_CH-1:0] receiveSignalLost, // receive_signal_lost pins
    input wire logic [`CHIRQ_NUM_CH-1:0] transmitDriveMonitor, // transmit_drive_monitor pins
    output logic irqOut // level interrupt, high while unmasked event
);
    chirq_bank_state_type state_q, state_d;

    logic [`CHIRQ_COND_W-1:0] condRaw;
    logic [`CHIRQ_COND_W-1:0] condSync;
    logic [`CHIRQ_NUM_CH-1:0][`CHIRQ_NUM_COND-1:0] chanCond;
    logic [`CHIRQ_NUM_CH-1:0][`CHIRQ_NUM_COND-1:0] chanEnableOut;
    logic [`CHIRQ_NUM_CH-1:0][`CHIRQ_NUM_COND-1:0] chanStatusOut;
    logic [`CHIRQ_NUM_CH-1:0] chanPending;
    logic [`CHIRQ_NUM_CH-1:0] srcEnableWr;
    logic [`CHIRQ_NUM_CH-1:0] srcStatusRd;
    logic [3:0] addrHi;
    logic [3:0] addrLo;
    logic chanHit;
    logic [3:0] chanIdx;
    logic [`CHIRQ_NUM_CH-1:0] pendRise;
    logic [7:0] rdValue;
    logic [1:0] ctlSel;

    assign addrHi = addr[7:4];
    assign addrLo = addr[3:0];

    // (R9) channel blocks at 0x0-0x5 and 0x8-0xD
    always_comb begin
        chanHit = (addrHi[2:0] <= 3'h5);
        chanIdx = addrHi[3] ? ({1'b0, addrHi[2:0]} + 4'h6) : {1'b0, addrHi[2:0]};
    end

    assign ctlSel = addrLo[1:0];

    genvar ch;
    generate
        for (ch = 0; ch < `CHIRQ_NUM_CH; ch = ch + 1) begin : gChan
            // pin order per channel follows the condition bit positions
            assign condRaw[ch*`CHIRQ_NUM_COND + `CHIRQ_BIT_DRIVE_MON] = transmitDriveMonitor[ch];
            assign condRaw[ch*`CHIRQ_NUM_COND + `CHIRQ_BIT_SIGNAL_LOST] = receiveSignalLost[ch];
            assign condRaw[ch*`CHIRQ_NUM_COND + `CHIRQ_BIT_LOCK_LOST] = receiveLockLost[ch];
            assign condRaw[ch*`CHIRQ_NUM_COND + `CHIRQ_BIT_BUF_LIMIT] = bufLimitAlarm[ch];
            assign chanCond[ch] = condSync[ch*`CHIRQ_NUM_COND +: `CHIRQ_NUM_COND];
            // (R8) one identical register set per channel
            assign srcEnableWr[ch] = wrStrobe && chanHit && (chanIdx == 4'(ch))
                && (addrLo == `CHIRQ_LO_SRC_ENABLE);
            assign srcStatusRd[ch] = rdStrobe && chanHit && (chanIdx == 4'(ch))
                && (addrLo == `CHIRQ_LO_SRC_STATUS);

            chirq_chan uChan (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .condIn(chanCond[ch]),
                .enableWr(srcEnableWr[ch]),
                .enableData(wrData[`CHIRQ_NUM_COND-1:0]),
                .statusRd(srcStatusRd[ch]),
                .enableOut(chanEnableOut[ch]),
                .statusOut(chanStatusOut[ch]),
                .pending(chanPending[ch])
            );
        end
    endgenerate

    chirq_sync uSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn(condRaw),
        .syncOut(condSync)
    );

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rdValue = `CHIRQ_RST_BYTE;
        if (chanHit) begin
            if (addrLo == `CHIRQ_LO_SRC_ENABLE) begin
                rdValue = {4'h0, chanEnableOut[chanIdx]};
            end else if (addrLo == `CHIRQ_LO_SRC_STATUS) begin
                rdValue = {4'h0, chanStatusOut[chanIdx]};
            end else if (addrLo == `CHIRQ_LO_ALARM_STATUS) begin
                rdValue = {4'h0, chanCond[chanIdx]};
            end else if (addrLo >= `CHIRQ_LO_CTL_FIRST && addrLo <= `CHIRQ_LO_CTL_LAST) begin
                rdValue = state_q.ctl[chanIdx][ctlSel];
            end else begin
                // protection switch and error counter locations read zero here
                rdValue = `CHIRQ_RST_BYTE;
            end
        end else begin
            case (addr)
                // (R2) (R10) low summary, top two bits zero
                `CHIRQ_ADDR_SUM_LOW: begin
                    rdValue = {2'b00, chanPending[`CHIRQ_HALF_CH-1:0]};
                end
                // (R1) (R10) high summary, top two bits zero
                `CHIRQ_ADDR_SUM_HIGH: begin
                    rdValue = {2'b00, chanPending[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH]};
                end
                `CHIRQ_ADDR_CIE_LOW: begin
                    rdValue = {2'b00, state_q.chanEnable[`CHIRQ_HALF_CH-1:0]};
                end
                `CHIRQ_ADDR_CIE_HIGH: begin
                    rdValue = {2'b00, state_q.chanEnable[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH]};
                end
                // (R6) fixed part number
                `CHIRQ_ADDR_PART: begin
                    rdValue = PART_ID;
                end
                // (R7) revision digit in low nibble
                `CHIRQ_ADDR_REV: begin
                    rdValue = {4'h0, REV_ID};
                end
                `CHIRQ_ADDR_EVT_LOW: begin
                    rdValue = {2'b00, state_q.evt[`CHIRQ_HALF_CH-1:0]};
                end
                `CHIRQ_ADDR_EVT_HIGH: begin
                    rdValue = {2'b00, state_q.evt[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH]};
                end
                `CHIRQ_ADDR_MASK_LOW: begin
                    rdValue = {2'b00, state_q.mask[`CHIRQ_HALF_CH-1:0]};
                end
                `CHIRQ_ADDR_MASK_HIGH: begin
                    rdValue = {2'b00, state_q.mask[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH]};
                end
                default: begin
                    rdValue = `CHIRQ_RST_BYTE;
                end
            endcase
        end
    end

    // a channel event is a new pending bit on an enabled channel
    assign pendRise = chanPending & ~state_q.pendPrev & state_q.chanEnable;

    always_comb begin
        state_d = state_q;
        state_d.pendPrev = chanPending;
        // read data stands only in the cycle after the strobe
        state_d.rdData = rdStrobe ? rdValue : `CHIRQ_RST_BYTE;
        if (wrStrobe && chanHit && addrLo >= `CHIRQ_LO_CTL_FIRST
            && addrLo <= `CHIRQ_LO_CTL_LAST) begin
            state_d.ctl[chanIdx][ctlSel] = wrData;
        end
        if (wrStrobe && !chanHit) begin
            case (addr)
                `CHIRQ_ADDR_CIE_LOW: begin
                    state_d.chanEnable[`CHIRQ_HALF_CH-1:0] = wrData[`CHIRQ_HALF_CH-1:0];
                end
                `CHIRQ_ADDR_CIE_HIGH: begin
                    state_d.chanEnable[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH] =
                        wrData[`CHIRQ_HALF_CH-1:0];
                end
                `CHIRQ_ADDR_MASK_LOW: begin
                    state_d.mask[`CHIRQ_HALF_CH-1:0] = wrData[`CHIRQ_HALF_CH-1:0];
                end
                `CHIRQ_ADDR_MASK_HIGH: begin
                    state_d.mask[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH] = wrData[`CHIRQ_HALF_CH-1:0];
                end
                `CHIRQ_ADDR_EVT_LOW: begin
                    state_d.evt[`CHIRQ_HALF_CH-1:0] =
                        state_q.evt[`CHIRQ_HALF_CH-1:0] & ~wrData[`CHIRQ_HALF_CH-1:0];
                end
                `CHIRQ_ADDR_EVT_HIGH: begin
                    state_d.evt[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH] =
                        state_q.evt[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH] & ~wrData[`CHIRQ_HALF_CH-1:0];
                end
                default: begin
                    // summary, part number and revision ignore writes
                    state_d.evt = state_d.evt;
                end
            endcase
        end
        // a new event beats a clear written in the same cycle
        state_d.evt = state_d.evt | pendRise;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
    assign irqOut = |(state_q.evt & state_q.mask);

    // helper copies for checking the read path
    logic [`CHIRQ_NUM_CH-1:0] pendAtRead;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pendAtRead <= `CHIRQ_RST_CH;
        end else begin
            pendAtRead <= chanPending;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sum_high_read_a: assert property (rdStrobe && addr == `CHIRQ_ADDR_SUM_HIGH
        |=> rdData == {2'b00, pendAtRead[`CHIRQ_NUM_CH-1:`CHIRQ_HALF_CH]}) // R1
        else $error("high summary read does not match channels 11 to 6");
    sum_low_read_a: assert property (rdStrobe && addr == `CHIRQ_ADDR_SUM_LOW
        |=> rdData == {2'b00, pendAtRead[`CHIRQ_HALF_CH-1:0]}) // R2
        else $error("low summary read does not match channels 0 to 5");
    sum_reserved_a: assert property (rdStrobe && (addr == `CHIRQ_ADDR_SUM_LOW
        || addr == `CHIRQ_ADDR_SUM_HIGH) |=> rdData[7:6] == 2'b00) // R10
        else $error("summary reserved bits not zero");
    part_fixed_a: assert property (rdStrobe && addr == `CHIRQ_ADDR_PART
        |=> rdData == PART_ID) // R6
        else $error("part number read wrong");
    rev_nibble_a: assert property (rdStrobe && addr == `CHIRQ_ADDR_REV
        |=> rdData[7:4] == 4'h0 && rdData[3:0] == REV_ID) // R7
        else $error("revision register read wrong");
    ctl_roundtrip_a: assert property (wrStrobe && chanHit && addrLo == `CHIRQ_LO_CTL_FIRST
        ##1 rdStrobe && addr == $past(addr) |=> rdData == $past(wrData, 2)) // R8
        else $error("per-channel control register lost written value");
    unmapped_zero_a: assert property (rdStrobe && !chanHit && (addrLo == 4'h7)
        |=> rdData == 8'h00) // R9
        else $error("unmapped global address did not read zero");
    sum_sticky_a: assert property (chanPending[0] && !srcStatusRd[0]
        |=> chanPending[0]) // R4
        else $error("channel 0 summary bit cleared without status read");
    evt_capture_a: assert property (|pendRise |=> |state_q.evt) // R3
        else $error("new pending channel did not set event status");
    data_one_cycle_a: assert property (!rdStrobe |=> rdData == 8'h00) // R9
        else $error("read data stood outside the answer cycle");
endmodule : chirq_bank

`default_nettype wire

// *** hw/chirq_defines.svh ***
// register offsets, field positions, reset values and sizes of the channel interrupt bank
// included by the package and by the testbench; definitions only
`ifndef CHIRQ_DEFINES_SVH
`define CHIRQ_DEFINES_SVH

`define CHIRQ_NUM_CH 12
`define CHIRQ_HALF_CH 6
`define CHIRQ_NUM_COND 4
`define CHIRQ_COND_W 48
`define CHIRQ_NUM_CTL 4

// low address nibble inside a channel block
`define CHIRQ_LO_PSW_CONTROL 4'h0
`define CHIRQ_LO_SRC_ENABLE 4'h1
`define CHIRQ_LO_SRC_STATUS 4'h2
`define CHIRQ_LO_ALARM_STATUS 4'h3
`define CHIRQ_LO_CTL_FIRST 4'h4
`define CHIRQ_LO_CTL_LAST 4'h7
`define CHIRQ_LO_PSW_STATUS 4'h8
`define CHIRQ_LO_ERR_FIRST 4'hA
`define CHIRQ_LO_ERR_LAST 4'hC

// global registers
`define CHIRQ_ADDR_CIE_LOW 8'h60
`define CHIRQ_ADDR_SUM_LOW 8'h61
`define CHIRQ_ADDR_PART 8'h6E
`define CHIRQ_ADDR_REV 8'h6F
`define CHIRQ_ADDR_EVT_LOW 8'h70
`define CHIRQ_ADDR_MASK_LOW 8'h71
`define CHIRQ_ADDR_CIE_HIGH 8'hE0
`define CHIRQ_ADDR_SUM_HIGH 8'hE1
`define CHIRQ_ADDR_EVT_HIGH 8'hF0
`define CHIRQ_ADDR_MASK_HIGH 8'hF1

// condition bit positions within a channel
`define CHIRQ_BIT_DRIVE_MON 0
`define CHIRQ_BIT_SIGNAL_LOST 1
`define CHIRQ_BIT_LOCK_LOST 2
`define CHIRQ_BIT_BUF_LIMIT 3

`define CHIRQ_RST_BYTE 8'h00
`define CHIRQ_RST_NIB 4'h0
`define CHIRQ_RST_CH 12'h000

`endif

// *** hw/chirq_pkg.sv ***
// state types of the channel interrupt bank
// assumes chirq_defines.svh on the include path
`include "chirq_defines.svh"

package chirq_pkg;

    typedef struct packed {
        logic [`CHIRQ_COND_W-1:0] stage1;
        logic [`CHIRQ_COND_W-1:0] stage2;
    } chirq_sync_state_type;

    typedef struct packed {
        logic primed;
        logic [`CHIRQ_NUM_COND-1:0] prevCond;
        logic [`CHIRQ_NUM_COND-1:0] enable;
        logic [`CHIRQ_NUM_COND-1:0] status;
    } chirq_chan_state_type;

    typedef struct packed {
        logic [`CHIRQ_NUM_CH-1:0][`CHIRQ_NUM_CTL-1:0][7:0] ctl;
        logic [`CHIRQ_NUM_CH-1:0] chanEnable;
        logic [`CHIRQ_NUM_CH-1:0] evt;
        logic [`CHIRQ_NUM_CH-1:0] mask;
        logic [`CHIRQ_NUM_CH-1:0] pendPrev;
        logic [7:0] rdData;
    } chirq_bank_state_type;

endpackage : chirq_pkg

// *** hw/chirq_sync.sv ***
// two-stage synchroniser for the line condition pins
// assumes the pins change asynchronously to ref_clk
`timescale 1ns/1ps
`default_nettype none

module chirq_sync import chirq_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [`CHIRQ_COND_W-1:0] asyncIn, // raw condition pins
    output logic [`CHIRQ_COND_W-1:0] syncOut // levels safe to use
);
    chirq_sync_state_type state_q, state_d;

    always_comb begin
        state_d = state_q;
        state_d.stage1 = asyncIn;
        state_d.stage2 = state_q.stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.stage2;
endmodule : chirq_sync

`default_nettype wire

// *** hw/chirq_chan.sv ***
// source-level interrupt logic of one channel: enable, sticky status, pending bit
// assumes synchronised condition levels and one-cycle strobes from the bank
`timescale 1ns/1ps
`default_nettype none

module chirq_chan import chirq_pkg::*; (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [`CHIRQ_NUM_COND-1:0] condIn, // synchronised conditions
    input wire logic enableWr, // write to source_irq_enable
    input wire logic [`CHIRQ_NUM_COND-1:0] enableData, // new enable bits
    input wire logic statusRd, // host reads source_irq_status
    output logic [`CHIRQ_NUM_COND-1:0] enableOut, // source_irq_enable
    output logic [`CHIRQ_NUM_COND-1:0] statusOut, // source_irq_status
    output logic pending // channel summary bit
);
    chirq_chan_state_type state_q, state_d;
    logic [`CHIRQ_NUM_COND-1:0] change;

    always_comb begin
        state_d = state_q;
        // no edge is seen until one sampled level exists
        change = state_q.primed ? (condIn ^ state_q.prevCond) : `CHIRQ_RST_NIB;
        state_d.prevCond = condIn;
        state_d.primed = 1'b1;
        if (enableWr) begin
            state_d.enable = enableData;
        end
        // (R4) cleared by status read
        if (statusRd) begin
            state_d.status = `CHIRQ_RST_NIB;
        end
        // (R11) declare or clear sets, beats the read clear
        state_d.status = state_d.status | (change & state_q.enable);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign enableOut = state_q.enable;
    assign statusOut = state_q.status;
    // (R3) set while any source awaits service
    assign pending = |state_q.status;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    change_sets_a: assert property ((|change) && (|(change & state_q.enable)) |=> pending) // R11
        else $error("enabled condition change did not raise pending");
    pend_holds_a: assert property (pending && !statusRd |=> pending) // R4
        else $error("pending dropped without a status read");
    pend_clear_a: assert property (pending && statusRd && !(|(change & state_q.enable))
        |=> !pending) // R3
        else $error("pending stayed after status read with no new event");
endmodule : chirq_chan

`default_nettype wire

// *** test/chirq_host.sv ***
// host processor model on the register port of the channel interrupt bank
// assumes the bank samples strobes on the rising edge of ref_clk and never waits
`timescale 1ns/1ps
`default_nettype none

module chirq_host (
    input wire logic ref_clk, // system clock
    output var logic [7:0] addr, // register address
    output var logic [7:0] wrData, // write data
    output var logic wrStrobe, // write strobe
    output var logic rdStrobe, // read strobe
    input wire logic [7:0] rdData // read data
);
    initial begin
        addr = 8'h00;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
    endtask : wr

    // read data is only valid in the cycle after the strobe, so take it just past that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1;
        d = rdData;
    endtask : rd

    // write then read with no idle cycle between the strobes
    task automatic wrRd(input logic [7:0] a, input logic [7:0] dw, output logic [7:0] dr);
        @(posedge ref_clk);
        addr <= a;
        wrData <= dw;
        wrStrobe <= 1'b1;
        @(posedge ref_clk);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        @(posedge ref_clk);
        rdStrobe <= 1'b0;
        #1;
        dr = rdData;
    endtask : wrRd

    task automatic service(input logic [7:0] sumAddr, input logic [7:0] srcAddr,
                           output logic [7:0] sum, output logic [7:0] src);
        rd(sumAddr, sum);
        rd(srcAddr, src);
    endtask : service
endmodule : chirq_host
`default_nettype wire

// *** test/test_chirq_bank.sv ***
// self-checking bench for the channel interrupt bank
// assumes chirq_defines.svh on the include path and the host model beside it
`timescale 1ns/1ps
`default_nettype none
`include "chirq_defines.svh"

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errTotal++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module test_chirq_bank;
    localparam logic [7:0] TB_PART = 8'h3C; // value is arbitrary
    localparam logic [3:0] TB_REV = 4'h9; // value is arbitrary
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] rdData;
    logic irqOut;
    logic [11:0] bufLimitAlarm = 12'h000;
    logic [11:0] receiveLockLost = 12'h000;
    logic [11:0] receiveSignalLost = 12'h000;
    logic [11:0] transmitDriveMonitor = 12'h000;
    int errTotal = 0;
    int comparisons = 0;
    int c;
    logic [7:0] d;
    logic [7:0] s;
    logic [7:0] sa;
    logic [7:0] sb;

    always #2.5 ref_clk = ~ref_clk;

    chirq_bank #(.PART_ID(TB_PART), .REV_ID(TB_REV)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .bufLimitAlarm(bufLimitAlarm), .receiveLockLost(receiveLockLost),
        .receiveSignalLost(receiveSignalLost), .transmitDriveMonitor(transmitDriveMonitor),
        .irqOut(irqOut)
    );

    chirq_host host (
        .ref_clk(ref_clk), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData)
    );

    function automatic logic [7:0] chAddr(input int ch, input logic [3:0] lo);
        logic [3:0] hi;
        hi = (ch < 6) ? ch[3:0] : ch[3:0] + 4'h2;
        return {hi, lo};
    endfunction : chAddr

    task automatic chkRd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        `CHK($sformatf("read %h", a), e, v)
    endtask : chkRd

    // pins change after an edge; six edges cover the three-edge path to the status bit
    task automatic tog(input int ch, input int cond);
        @(posedge ref_clk);
        case (cond)
            0: transmitDriveMonitor[ch] <= ~transmitDriveMonitor[ch];
            1: receiveSignalLost[ch] <= ~receiveSignalLost[ch];
            2: receiveLockLost[ch] <= ~receiveLockLost[ch];
            default: bufLimitAlarm[ch] <= ~bufLimitAlarm[ch];
        endcase
        repeat (6) @(posedge ref_clk);
    endtask : tog

    task automatic results;
        if (errTotal == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        `CHK("irqOut", 1'b0, irqOut)
        chkRd(8'h6E, TB_PART);
        host.wr(8'h6E, ~TB_PART);
        chkRd(8'h6E, TB_PART);
        chkRd(8'h6F, {4'h0, TB_REV});
        host.wr(8'hE1, 8'hFF);
        chkRd(8'hE1, 8'h00);
        chkRd(8'h61, 8'h00);
        chkRd(8'h77, 8'h00);
        chkRd(8'h09, 8'h00);
        @(posedge ref_clk);
        #1;
        `CHK("rdData idle", 8'h00, rdData)
        // all writes land before any read so that aliased decodes show up
        for (int ch = 0; ch < 12; ch++) begin
            for (int lo = 4; lo < 8; lo++) begin
                host.wr(chAddr(ch, lo[3:0]), {ch[3:0], lo[3:0]});
            end
            host.wr(chAddr(ch, `CHIRQ_LO_SRC_ENABLE), 8'hFF);
        end
        for (int ch = 0; ch < 12; ch++) begin
            for (int lo = 4; lo < 8; lo++) begin
                chkRd(chAddr(ch, lo[3:0]), {ch[3:0], lo[3:0]});
            end
            chkRd(chAddr(ch, `CHIRQ_LO_SRC_ENABLE), 8'h0F);
        end
        host.wrRd(chAddr(0, 4'h4), 8'h5A, d);
        `CHK("ctl back to back", 8'h5A, d)
        for (int ch = 0; ch < 12; ch++) begin
            c = ch % 4;
            tog(ch, c);
            sa = (ch < 6) ? 8'h61 : 8'hE1;
            sb = 8'h01 << (ch % 6);
            chkRd(sa, sb);
            chkRd(chAddr(ch, `CHIRQ_LO_ALARM_STATUS), 8'h01 << c);
            host.service(sa, chAddr(ch, `CHIRQ_LO_SRC_STATUS), s, d);
            `CHK("summary held", sb, s)
            `CHK("source status", 8'h01 << c, d)
            chkRd(sa, 8'h00);
        end
        // clearing every condition at once is an event on all twelve channels
        @(posedge ref_clk);
        transmitDriveMonitor <= 12'h000;
        receiveSignalLost <= 12'h000;
        receiveLockLost <= 12'h000;
        bufLimitAlarm <= 12'h000;
        repeat (6) @(posedge ref_clk);
        chkRd(8'h61, 8'h3F);
        chkRd(8'hE1, 8'h3F);
        for (int ch = 0; ch < 12; ch++) begin
            chkRd(chAddr(ch, `CHIRQ_LO_SRC_STATUS), 8'h01 << (ch % 4));
        end
        chkRd(8'h61, 8'h00);
        chkRd(8'hE1, 8'h00);
        host.wr(chAddr(3, `CHIRQ_LO_SRC_ENABLE), 8'h00);
        tog(3, 0);
        chkRd(8'h61, 8'h00);
        host.wr(8'h60, 8'h01);
        host.wr(8'h71, 8'h01);
        tog(0, 1);
        #1;
        `CHK("irqOut raised", 1'b1, irqOut)
        chkRd(8'h70, 8'h01);
        host.wr(8'h71, 8'h00);
        #1;
        `CHK("irqOut masked", 1'b0, irqOut)
        host.wr(8'h71, 8'h01);
        #1;
        `CHK("irqOut unmasked", 1'b1, irqOut)
        host.wr(8'h70, 8'h01);
        #1;
        `CHK("irqOut cleared", 1'b0, irqOut)
        chkRd(8'h70, 8'h00);
        tog(6, 2);
        chkRd(8'hF0, 8'h00);
        chkRd(8'hE1, 8'h01);
        results();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        errTotal++;
        results();
    end
endmodule : test_chirq_bank
`default_nettype wire
